// ### rtl/ssm_pkg.sv
// constants and types shared by the smart switch mode machine
package ssm_pkg;
  // operating modes, one-hot
  typedef enum logic [5:0] {
    SSM_OFF = 6'b00_0001,
    SSM_STANDBY = 6'b00_0010,
    SSM_STBY_DLY = 6'b00_0100,
    SSM_DIAG = 6'b00_1000,
    SSM_ACTIVE = 6'b01_0000,
    SSM_FAULT = 6'b10_0000
  } ssm_state_t;
  // sense output selection
  typedef enum logic [2:0] {
    SSM_SNS_OFF = 3'h0,
    SSM_SNS_CURRENT = 3'h1,
    SSM_SNS_TEMP = 3'h2,
    SSM_SNS_FAULT = 3'h4
  } ssm_sense_t;
  localparam int SSM_CLK_HZ = 10_000_000;
  localparam int SSM_STBY_US = 1000;
  localparam int SSM_RETRY_US = 1000;
  localparam int SSM_STBY_CYC = (SSM_STBY_US * (SSM_CLK_HZ / 1_000_000));
  localparam int SSM_RETRY_CYC = (SSM_RETRY_US * (SSM_CLK_HZ / 1_000_000));
  localparam logic [15:0] SSM_TIMER_RST = 16'h0000;
endpackage

// ### rtl/ssm_timer_if.sv
// start and expiry handshake between mode machine and delay timer
`timescale 1ns/1ps
interface ssm_timer_if;
  logic start;
  logic running;
  logic expired;
  modport ctrl (output start, input running, input expired);
  modport tmr (input start, output running, output expired);
endinterface

// ### rtl/ssm_timer.sv
// down-counting delay timer with restart and one-cycle expiry pulse
`timescale 1ns/1ps
module ssm_timer import ssm_pkg::*; #(
  parameter int Cycles = 1000
) (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset, high
  ssm_timer_if.tmr tif // timer handshake
);
  logic [15:0] cnt_q;
  // restart reloads; expiry fires once when count reaches one
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= SSM_TIMER_RST;
    end else if (tif.start) begin
      cnt_q <= 16'(Cycles);
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
  assign tif.running = (cnt_q != 16'h0000);
  // plain count compare keeps the start-to-expiry path free of a loop through the caller
  assign tif.expired = (cnt_q == 16'h0001);
endmodule

// ### rtl/ssm_mode_fsm.sv
// operating-mode state machine of a single-channel smart high-side switch
// What this block does
// - fault detect on retry wait, open load
// - standby: lowest power, no diagnostics
// - diagnostic state runs with switch off
// - both enables low: delay, then standby
// - active: switch on, diagnostics switchable
// - in active, thermal or current-limit shutdown enters fault
// - leave fault: cleared, unlatched, retry expired
// - after fault, switch follows enable input
// - ground loss disables switch until restored
// - fault level only with select low
// - no fault: select chooses current or temperature
// - open-load flag clears on enable edges
`timescale 1ns/1ps
module ssm_mode_fsm import ssm_pkg::*; #(
  parameter int StbyCycles = SSM_STBY_CYC,
  parameter int RetryCycles = SSM_RETRY_CYC
) (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset, high
  input wire logic powerGood, // supply present
  input wire logic enableIn, // switch enable pin
  input wire logic diag_enable_input, // diagnostic enable pin
  input wire logic latchIn, // latch-off select pin
  input wire logic sense_select_input, // sense mux select
  input wire logic thermalShutdown, // overtemperature event level
  input wire logic currentLimit, // current-limit event level
  input wire logic openLoadDetect, // output above open-load threshold
  input wire logic groundLost, // device ground missing
  output logic switchOn, // power fet gate drive
  output logic diagActive, // diagnostic circuits powered
  output logic lowPower, // standby power mode
  output logic faultDetect, // internal fault detect
  output logic senseDrive, // sense output driven
  output ssm_sense_t sense_output, // sense mux choice
  output ssm_state_t modeState // current mode
);
  ssm_state_t state_q;
  ssm_state_t state_d;
  logic enPrev_q;
  logic diagPrev_q;
  logic openLoadFlag_q;
  logic openLoadFlag_d;
  logic shutFault;
  logic stbyStart;
  logic retryStart;
  ssm_timer_if stbyIf();
  ssm_timer_if retryIf();

  assign shutFault = thermalShutdown || currentLimit;

  // one timer for standby delay, one for retry; both restart on entry
  ssm_timer #(.Cycles(StbyCycles)) stbyTimer (
    .clk(clk),
    .srst(srst),
    .tif(stbyIf)
  );
  ssm_timer #(.Cycles(RetryCycles)) retryTimer (
    .clk(clk),
    .srst(srst),
    .tif(retryIf)
  );
  assign stbyStart = (state_d == SSM_STBY_DLY) && (state_q != SSM_STBY_DLY);
  // retry restarts while a shutdown persists, so expiry follows the last fault
  assign retryStart = (state_d == SSM_FAULT) && (state_q != SSM_FAULT || shutFault);
  assign stbyIf.start = stbyStart;
  assign retryIf.start = retryStart;

  // next-mode decision
  always_comb begin
    state_d = state_q;
    case (state_q)
      SSM_OFF: begin
        if (powerGood) begin
          if (enableIn) begin
            state_d = SSM_ACTIVE;
          end else if (diag_enable_input) begin
            state_d = SSM_DIAG;
          end else begin
            state_d = SSM_STBY_DLY;
          end
        end
      end
      SSM_STANDBY, SSM_DIAG, SSM_STBY_DLY: begin
        if (enableIn) begin
          state_d = SSM_ACTIVE;
        end else if (diag_enable_input) begin
          state_d = SSM_DIAG;
        end else if (state_q == SSM_DIAG) begin
          state_d = SSM_STBY_DLY;
        end else if (state_q == SSM_STBY_DLY && stbyIf.expired) begin
          state_d = SSM_STANDBY;
        end
      end
      SSM_ACTIVE: begin
        if (shutFault) begin
          state_d = SSM_FAULT;
        end else if (!enableIn) begin
          state_d = diag_enable_input ? SSM_DIAG : SSM_STBY_DLY;
        end
      end
      SSM_FAULT: begin
        // latch high holds the fault until latch goes low or power drops
        if (!shutFault && !latchIn && !retryIf.running) begin
          if (enableIn) begin
            state_d = SSM_ACTIVE;
          end else begin
            state_d = diag_enable_input ? SSM_DIAG : SSM_STBY_DLY;
          end
        end
      end
      default: state_d = SSM_OFF;
    endcase
    if (!powerGood) begin
      state_d = SSM_OFF;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= SSM_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // edge history of the two enable pins
  always_ff @(posedge clk) begin
    if (srst) begin
      enPrev_q <= 1'b0;
      diagPrev_q <= 1'b0;
    end else begin
      enPrev_q <= enableIn;
      diagPrev_q <= diag_enable_input;
    end
  end

  // open-load flag follows comparator with switch off; edges clear, new set wins
  // next value feeds the outputs so a clearing edge is not reported one cycle late
  always_comb begin
    openLoadFlag_d = openLoadFlag_q;
    if (diag_enable_input && !enableIn && openLoadDetect && state_d == SSM_DIAG) begin
      openLoadFlag_d = 1'b1;
    end else if ((diagPrev_q && !diag_enable_input) || (!enPrev_q && enableIn)) begin
      openLoadFlag_d = 1'b0;
    end else if (!openLoadDetect || state_d != SSM_DIAG) begin
      openLoadFlag_d = 1'b0;
    end
  end

  // open-load flag register
  always_ff @(posedge clk) begin
    if (srst) begin
      openLoadFlag_q <= 1'b0;
    end else begin
      openLoadFlag_q <= openLoadFlag_d;
    end
  end

  // registered outputs derived from the next mode
  always_ff @(posedge clk) begin
    if (srst) begin
      switchOn <= 1'b0;
      diagActive <= 1'b0;
      lowPower <= 1'b0;
      faultDetect <= 1'b0;
      senseDrive <= 1'b0;
      sense_output <= SSM_SNS_OFF;
      modeState <= SSM_OFF;
    end else begin
      modeState <= state_d;
      // ground loss forces the fet off without disturbing the mode
      switchOn <= (state_d == SSM_ACTIVE) && !groundLost;
      lowPower <= (state_d == SSM_STANDBY);
      diagActive <= diag_enable_input && !groundLost &&
                    (state_d == SSM_DIAG || state_d == SSM_ACTIVE ||
                     state_d == SSM_FAULT);
      faultDetect <= (state_d == SSM_FAULT) || openLoadFlag_d;
      senseDrive <= diag_enable_input && !groundLost && state_d != SSM_STANDBY &&
                    state_d != SSM_OFF;
      if (!diag_enable_input || groundLost || state_d == SSM_STANDBY ||
          state_d == SSM_OFF) begin
        sense_output <= SSM_SNS_OFF;
      end else if (sense_select_input) begin
        sense_output <= SSM_SNS_TEMP;
      end else if ((state_d == SSM_FAULT) || openLoadFlag_d) begin
        sense_output <= SSM_SNS_FAULT;
      end else begin
        sense_output <= SSM_SNS_CURRENT;
      end
    end
  end

  // checks
  standby_entry_a: assert property (@(posedge clk) disable iff (srst)
    (state_q == SSM_STBY_DLY && state_d == SSM_STANDBY) |-> stbyIf.expired &&
    !enableIn && !diag_enable_input)
    else $error("standby entered early");
  shut_fault_a: assert property (@(posedge clk) disable iff (srst)
    (state_q == SSM_ACTIVE && shutFault && powerGood) |=> state_q == SSM_FAULT)
    else $error("shutdown did not enter fault");
  fault_exit_a: assert property (@(posedge clk) disable iff (srst)
    (state_q == SSM_FAULT && state_d != SSM_FAULT && powerGood) |->
    !latchIn && !shutFault && !retryIf.running)
    else $error("fault left too soon");
  retry_target_a: assert property (@(posedge clk) disable iff (srst)
    (state_q == SSM_FAULT && state_d != SSM_FAULT && powerGood) |->
    ((state_d == SSM_ACTIVE) == enableIn))
    else $error("wrong state after fault");
  gnd_off_a: assert property (@(posedge clk) disable iff (srst)
    groundLost |=> !switchOn)
    else $error("switch on without ground");
  switch_mode_a: assert property (@(posedge clk) disable iff (srst)
    switchOn |-> modeState == SSM_ACTIVE)
    else $error("switch on outside active");
  standby_quiet_a: assert property (@(posedge clk) disable iff (srst)
    lowPower |-> !diagActive && !senseDrive && !switchOn)
    else $error("diagnostics in standby");
  sense_fault_a: assert property (@(posedge clk) disable iff (srst)
    (sense_output == SSM_SNS_FAULT) |-> faultDetect && !$past(sense_select_input))
    else $error("fault level with select high");
  power_up_a: assert property (@(posedge clk) disable iff (srst)
    (state_q == SSM_OFF && powerGood) |=> state_q != SSM_OFF)
    else $error("stuck in off");
  standby_timer_a: assert property (@(posedge clk) disable iff (srst)
    (state_q == SSM_STANDBY) |-> !stbyIf.running)
    else $error("standby with delay still running");
  retry_cov: cover property (@(posedge clk) disable iff (srst)
    state_q == SSM_FAULT ##1 state_q == SSM_ACTIVE);
  standby_cov: cover property (@(posedge clk) disable iff (srst)
    state_q == SSM_STBY_DLY ##1 state_q == SSM_STANDBY);
  openload_cov: cover property (@(posedge clk) disable iff (srst)
    openLoadFlag_q ##1 !openLoadFlag_q);
  diag_cov: cover property (@(posedge clk) disable iff (srst)
    state_q == SSM_DIAG ##1 state_q == SSM_ACTIVE);
  retry_expiry_cov: cover property (@(posedge clk) disable iff (srst)
    retryIf.expired ##2 state_q != SSM_FAULT);
endmodule

// ### sim/ssm_mcu_model.sv
// controller model: drives the control pins, samples the sense mux
`timescale 1ns/1ps
module ssm_mcu_model import ssm_pkg::*; #(
  parameter int SettleCycles = 2
) (
  input wire logic clk, // system clock
  input ssm_sense_t senseIn, // sense level seen at the adc
  output logic enableOut, // switch enable pin
  output logic diagOut, // diagnostic enable pin
  output logic latchOut, // latch-off select pin
  output logic selectOut // sense mux select
);
  // pins low at power-up so the switch never starts on by accident
  initial begin
    {enableOut, diagOut, latchOut, selectOut} = 4'h0;
  end
  // called just after a rising edge; one adc per device, no shared resistor
  task automatic setPins(input logic [3:0] p);
    {enableOut, diagOut, latchOut, selectOut} <= p;
  endtask
  // wait out the settling time before taking the sample
  task automatic sampleSense(output ssm_sense_t s);
    repeat (SettleCycles) @(posedge clk);
    #1 s = senseIn;
  endtask
endmodule

// ### sim/smart_switch_mode_fsm_tb.sv
// self-checking bench for the smart switch mode machine
`timescale 1ns/1ps
module smart_switch_mode_fsm_tb import ssm_pkg::*;;
  logic clk = 0, srst = 1, powerGood = 0, thermalShutdown = 0, currentLimit = 0;
  logic openLoadDetect = 0, groundLost = 0;
  logic enableIn, diag_enable_input, latchIn, sense_select_input;
  logic switchOn, diagActive, lowPower, faultDetect, senseDrive;
  ssm_sense_t sense_output, s;
  ssm_state_t modeState;
  int miscompares = 0, checks = 0, seed = 71056, m = 1, r;
  logic [8:0] v;
  // steps {pg, en, dia, latch, sel, thermal, climit, openload, gndlost}
  logic [8:0] steps [14] = '{9'h1c0, 9'h1d0, 9'h1c4, 9'h1d4, 9'h1c0, 9'h1e8, 9'h1e0,
    9'h0e0, 9'h142, 9'h102, 9'h181, 9'h180, 9'h188, 9'h100};
  initial forever #50 clk = ~clk;
  ssm_mode_fsm #(.StbyCycles(8), .RetryCycles(8)) dut_u (.clk(clk), .srst(srst),
    .powerGood(powerGood), .enableIn(enableIn), .diag_enable_input(diag_enable_input),
    .latchIn(latchIn), .sense_select_input(sense_select_input),
    .thermalShutdown(thermalShutdown), .currentLimit(currentLimit),
    .openLoadDetect(openLoadDetect), .groundLost(groundLost), .switchOn(switchOn),
    .diagActive(diagActive), .lowPower(lowPower), .faultDetect(faultDetect),
    .senseDrive(senseDrive), .sense_output(sense_output), .modeState(modeState));
  ssm_mcu_model mcu_u (.clk(clk), .senseIn(sense_output), .enableOut(enableIn),
    .diagOut(diag_enable_input), .latchOut(latchIn), .selectOut(sense_select_input));
  // reference mode after the timers have settled; fault sticks while latched
  function automatic int nextMode(int p, logic [8:0] x);
    if (!x[8]) return 1;
    if (p == 32 && (x[5] || x[3] || x[2])) return 32;
    if (p == 16 && (x[3] || x[2])) return 32;
    if (x[7]) return 16;
    if (x[6]) return 8;
    return 2;
  endfunction
  task automatic cmp(input logic [5:0] a, input logic [5:0] e);
    checks++;
    if (a !== e) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic chk_state(input ssm_state_t a, input ssm_state_t e);
    cmp(a, e);
  endtask
  task automatic chk_bit(input logic a, input logic e);
    cmp({5'h00, a}, {5'h00, e});
  endtask
  task automatic chk_sense(input ssm_sense_t a, input ssm_sense_t e);
    cmp({3'h0, a}, {3'h0, e});
  endtask
  task automatic tally_and_finish();
    $display("miscompares=%0d checks=%0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, far beyond the ~390 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 0;
    #1 chk_state(modeState, SSM_OFF);
    for (int i = 0; i < 14; i++) begin
      v = steps[i];
      @(posedge clk);
      {powerGood, thermalShutdown, currentLimit, openLoadDetect, groundLost} <=
        {v[8], v[3:0]};
      mcu_u.setPins(v[7:4]);
      // standby must wait out the delay first
      if (i == 9) begin
        repeat (3) @(posedge clk);
        #1 chk_state(modeState, SSM_STBY_DLY);
      end
      repeat (24) @(posedge clk);
      #1 m = nextMode(m, v);
      chk_state(modeState, ssm_state_t'(6'(m)));
      chk_bit(switchOn, m == 16 && !v[0]);
      chk_bit(lowPower, m == 2);
      chk_bit(diagActive, v[6] && !v[0] && m >= 8);
      chk_bit(senseDrive, v[6] && !v[0] && m > 2);
      chk_bit(faultDetect, m == 32 || (m == 8 && v[1]));
      chk_sense(sense_output, (!v[6] || v[0] || m < 4) ? SSM_SNS_OFF : v[4] ? SSM_SNS_TEMP :
        (m == 32 || (m == 8 && v[1])) ? SSM_SNS_FAULT : SSM_SNS_CURRENT);
    end
    // random select and open-load levels in diagnostic mode
    @(posedge clk);
    mcu_u.setPins(4'h4);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      r = $random(seed);
      openLoadDetect <= r[1];
      mcu_u.setPins({3'h2, r[0]});
      mcu_u.sampleSense(s);
      chk_bit(faultDetect, r[1]);
      chk_sense(s, r[0] ? SSM_SNS_TEMP : r[1] ? SSM_SNS_FAULT : SSM_SNS_CURRENT);
    end
    tally_and_finish();
  end
endmodule
